// *** verilog/bbf_exec.sv ***
`timescale 1ns/1ns
module bbf_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // instruction in
  input wire logic instr_valid,
  input wire bbf_pkg::bbf_instr_type instr,
  output logic ready_q,
  // general register operand and write-back
  input wire logic [7:0] reg_rd_data,
  output bbf_pkg::bbf_reg_wb_type reg_wb_q,
  // io space
  output logic [bbf_pkg::IO_ADDR_W-1:0] io_addr_q,
  input wire logic [7:0] io_rd_data,
  output logic io_wr_en_q,
  output logic [7:0] io_wr_data_q,
  // core state
  output logic [bbf_pkg::PC_W-1:0] pc_q,
  output logic [7:0] status_q
);

  typedef enum logic [1:0] {
    st_idle,
    st_branch_wait,
    st_io_write
  } bbf_state_type;

  bbf_state_type state_q;
  bbf_state_type state_d;
  logic accept;
  logic is_branch;
  logic br_signed;
  logic br_want_one;
  logic [2:0] br_sel;
  logic br_taken;
  logic [bbf_pkg::PC_W-1:0] pc_next;
  logic [bbf_pkg::PC_W-1:0] pc_branch;
  logic [bbf_pkg::PC_W-1:0] pc_d;
  logic is_shift;
  bbf_pkg::bbf_shift_type sh_kind;
  logic [7:0] sh_out;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic sh_s;
  logic force_flag;
  logic force_val;
  logic [2:0] force_sel;
  logic [7:0] status_d;
  logic io_force_val_q;
  logic [2:0] io_bit_q;

  assign accept = clk_en && instr_valid && ready_q && state_q == st_idle;

  // map every branch form onto a flag index and polarity; the signed forms test n xor v instead of an index
  always_comb begin
    is_branch = 1'b1;
    br_signed = 1'b0;
    br_want_one = 1'b1;
    br_sel = instr.sel;
    case (instr.op)
      bbf_pkg::op_branch_status_bit_set: begin
        br_want_one = 1'b1;
      end
      bbf_pkg::op_branch_status_bit_clear: begin
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_equal: begin
        br_sel = bbf_pkg::FLAG_Z;
      end
      bbf_pkg::op_branch_not_equal: begin
        br_sel = bbf_pkg::FLAG_Z;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_carry_one,
      bbf_pkg::op_branch_unsigned_lt: begin
        br_sel = bbf_pkg::FLAG_C;
      end
      bbf_pkg::op_branch_carry_zero,
      bbf_pkg::op_branch_unsigned_ge: begin
        br_sel = bbf_pkg::FLAG_C;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_negative: begin
        br_sel = bbf_pkg::FLAG_N;
      end
      bbf_pkg::op_branch_positive: begin
        br_sel = bbf_pkg::FLAG_N;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_signed_ge: begin
        br_signed = 1'b1;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_signed_lt: begin
        br_signed = 1'b1;
      end
      bbf_pkg::op_branch_half_carry_one: begin
        br_sel = bbf_pkg::FLAG_H;
      end
      bbf_pkg::op_branch_half_carry_zero: begin
        br_sel = bbf_pkg::FLAG_H;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_transfer_one: begin
        br_sel = bbf_pkg::FLAG_T;
      end
      bbf_pkg::op_branch_transfer_zero: begin
        br_sel = bbf_pkg::FLAG_T;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_overflow_one: begin
        br_sel = bbf_pkg::FLAG_V;
      end
      bbf_pkg::op_branch_overflow_zero: begin
        br_sel = bbf_pkg::FLAG_V;
        br_want_one = 1'b0;
      end
      bbf_pkg::op_branch_irq_enabled: begin
        br_sel = bbf_pkg::FLAG_I;
      end
      bbf_pkg::op_branch_irq_disabled: begin
        br_sel = bbf_pkg::FLAG_I;
        br_want_one = 1'b0;
      end
      default: begin
        is_branch = 1'b0;
      end
    endcase
  end

  bbf_branch_cond u_cond (
    .status(status_q),
    .sel(br_sel),
    .signed_cmp(br_signed),
    .want_one(br_want_one),
    .taken(br_taken)
  );

  // target counts words from the next instruction
  assign pc_next = pc_q + 16'h0001;
  assign pc_branch = pc_next + {{(bbf_pkg::PC_W-bbf_pkg::OFS_W){
    instr.offset[6]}}, instr.offset};

  always_comb begin
    is_shift = 1'b1;
    case (instr.op)
      bbf_pkg::op_shift_left_logical: sh_kind = bbf_pkg::sh_left_logical;
      bbf_pkg::op_shift_right_logical: sh_kind = bbf_pkg::sh_right_logical;
      bbf_pkg::op_rotate_left_carry: sh_kind = bbf_pkg::sh_rotate_left;
      bbf_pkg::op_rotate_right_carry: sh_kind = bbf_pkg::sh_rotate_right;
      bbf_pkg::op_shift_right_arith: sh_kind = bbf_pkg::sh_right_arith;
      default: begin
        sh_kind = bbf_pkg::sh_left_logical;
        is_shift = 1'b0;
      end
    endcase
  end

  bbf_shifter u_shift (
    .kind(sh_kind),
    .din(reg_rd_data),
    .cin(status_q[bbf_pkg::FLAG_C]),
    .dout(sh_out),
    .c(sh_c),
    .z(sh_z),
    .n(sh_n),
    .v(sh_v),
    .s(sh_s)
  );

  // single-flag forcing: dedicated forms and the indexed form
  always_comb begin
    force_flag = 1'b1;
    force_val = 1'b1;
    force_sel = instr.sel;
    case (instr.op)
      bbf_pkg::op_flag_force_one: force_val = 1'b1;
      bbf_pkg::op_flag_force_zero: force_val = 1'b0;
      bbf_pkg::op_carry_on: force_sel = bbf_pkg::FLAG_C;
      bbf_pkg::op_carry_off: begin
        force_sel = bbf_pkg::FLAG_C;
        force_val = 1'b0;
      end
      bbf_pkg::op_negative_on: force_sel = bbf_pkg::FLAG_N;
      bbf_pkg::op_negative_off: begin
        force_sel = bbf_pkg::FLAG_N;
        force_val = 1'b0;
      end
      bbf_pkg::op_zero_on: force_sel = bbf_pkg::FLAG_Z;
      bbf_pkg::op_zero_off: begin
        force_sel = bbf_pkg::FLAG_Z;
        force_val = 1'b0;
      end
      bbf_pkg::op_overflow_on: force_sel = bbf_pkg::FLAG_V;
      bbf_pkg::op_overflow_off: begin
        force_sel = bbf_pkg::FLAG_V;
        force_val = 1'b0;
      end
      bbf_pkg::op_signed_on: force_sel = bbf_pkg::FLAG_S;
      bbf_pkg::op_signed_off: begin
        force_sel = bbf_pkg::FLAG_S;
        force_val = 1'b0;
      end
      bbf_pkg::op_transfer_on: force_sel = bbf_pkg::FLAG_T;
      bbf_pkg::op_transfer_off: begin
        force_sel = bbf_pkg::FLAG_T;
        force_val = 1'b0;
      end
      bbf_pkg::op_global_irq_on: force_sel = bbf_pkg::FLAG_I;
      bbf_pkg::op_global_irq_off: begin
        force_sel = bbf_pkg::FLAG_I;
        force_val = 1'b0;
      end
      default: force_flag = 1'b0;
    endcase
  end

  // sequencing: taken branches and io forcing hold ready low one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: begin
        if (accept && is_branch && br_taken) begin
          state_d = st_branch_wait;
        end else if (accept && (instr.op == bbf_pkg::op_io_bit_force_one
            || instr.op == bbf_pkg::op_io_bit_force_zero)) begin
          state_d = st_io_write;
        end
      end
      st_branch_wait: state_d = st_idle;
      st_io_write: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
      ready_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      ready_q <= (state_d == st_idle);
    end
  end

  always_comb begin
    pc_d = pc_q;
    if (accept) begin
      if (is_branch && br_taken) begin
        pc_d = pc_branch;
      end else begin
        pc_d = pc_next;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_q <= bbf_pkg::PC_RESET;
    end else if (clk_en) begin
      pc_q <= pc_d;
    end
  end

  // branches and io forcing leave the flags alone
  always_comb begin
    status_d = status_q;
    if (accept && is_shift) begin
      status_d[bbf_pkg::FLAG_C] = sh_c;
      status_d[bbf_pkg::FLAG_Z] = sh_z;
      status_d[bbf_pkg::FLAG_N] = sh_n;
      status_d[bbf_pkg::FLAG_V] = sh_v;
      status_d[bbf_pkg::FLAG_S] = sh_s;
    end else if (accept && force_flag) begin
      status_d[force_sel] = force_val;
    end else if (accept && instr.op == bbf_pkg::op_bit_to_transfer_flag) begin
      status_d[bbf_pkg::FLAG_T] = reg_rd_data[instr.sel];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_q <= bbf_pkg::STATUS_RESET;
    end else if (clk_en) begin
      status_q <= status_d;
    end
  end

  // register write-back, one cycle pulse after acceptance
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_wb_q <= '0;
    end else if (clk_en) begin
      reg_wb_q.en <= 1'b0;
      if (accept && is_shift) begin
        reg_wb_q.en <= 1'b1;
        reg_wb_q.addr <= instr.reg_addr;
        reg_wb_q.data <= sh_out;
      end else if (accept
          && instr.op == bbf_pkg::op_transfer_flag_to_bit) begin
        reg_wb_q.en <= 1'b1;
        reg_wb_q.addr <= instr.reg_addr;
        reg_wb_q.data <= reg_rd_data;
        reg_wb_q.data[instr.sel] <= status_q[bbf_pkg::FLAG_T];
      end
    end
  end

  // io forcing: address out first cycle, modified byte written second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_addr_q <= '0;
      io_bit_q <= 3'h0;
      io_force_val_q <= 1'b0;
    end else if (clk_en && state_d == st_io_write && state_q == st_idle) begin
      io_addr_q <= instr.io_addr;
      io_bit_q <= instr.sel;
      io_force_val_q <= (instr.op == bbf_pkg::op_io_bit_force_one);
    end
  end

  // whole byte is written back, so write-one-to-clear bits that read
  // as one get cleared; software must expect that
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_wr_en_q <= 1'b0;
      io_wr_data_q <= 8'h00;
    end else if (clk_en) begin
      io_wr_en_q <= 1'b0;
      if (state_q == st_io_write) begin
        io_wr_en_q <= 1'b1;
        io_wr_data_q <= io_rd_data;
        io_wr_data_q[io_bit_q] <= io_force_val_q;
      end
    end
  end

endmodule : bbf_exec

// *** inc/bbf_pkg.sv ***
package bbf_pkg;

  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int REG_ADDR_W = 5;
  localparam int IO_ADDR_W = 5;

  // status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef enum logic [5:0] {
    op_nop,
    op_branch_status_bit_set, op_branch_status_bit_clear,
    op_branch_equal, op_branch_not_equal,
    op_branch_carry_one, op_branch_carry_zero,
    op_branch_unsigned_ge, op_branch_unsigned_lt,
    op_branch_negative, op_branch_positive,
    op_branch_signed_ge, op_branch_signed_lt,
    op_branch_half_carry_one, op_branch_half_carry_zero,
    op_branch_transfer_one, op_branch_transfer_zero,
    op_branch_overflow_one, op_branch_overflow_zero,
    op_branch_irq_enabled, op_branch_irq_disabled,
    op_io_bit_force_one, op_io_bit_force_zero,
    op_shift_left_logical, op_shift_right_logical,
    op_rotate_left_carry, op_rotate_right_carry,
    op_shift_right_arith,
    op_flag_force_one, op_flag_force_zero,
    op_bit_to_transfer_flag, op_transfer_flag_to_bit,
    op_carry_on, op_carry_off, op_negative_on, op_negative_off,
    op_zero_on, op_zero_off, op_overflow_on, op_overflow_off,
    op_signed_on, op_signed_off, op_transfer_on, op_transfer_off,
    op_global_irq_on, op_global_irq_off
  } bbf_op_type;

  typedef enum logic [2:0] {
    sh_left_logical, sh_right_logical, sh_rotate_left,
    sh_rotate_right, sh_right_arith
  } bbf_shift_type;

  // one decoded instruction; sel is the flag or bit index
  typedef struct packed {
    bbf_op_type op;
    logic [2:0] sel;
    logic [OFS_W-1:0] offset;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [IO_ADDR_W-1:0] io_addr;
  } bbf_instr_type;

  // register write-back
  typedef struct packed {
    logic en;
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0] data;
  } bbf_reg_wb_type;

endpackage : bbf_pkg

// *** verilog/bbf_branch_cond.sv ***
`timescale 1ns/1ns
module bbf_branch_cond (
  // status and selection
  input wire logic [7:0] status,
  input wire logic [2:0] sel,
  input wire logic signed_cmp,
  input wire logic want_one,
  // result
  output logic taken
);

  logic cond_bit;

  // signed compare looks at n and v directly, so a forced s flag
  // cannot fool it
  always_comb begin
    if (signed_cmp) begin
      cond_bit = status[bbf_pkg::FLAG_N] ^ status[bbf_pkg::FLAG_V];
    end else begin
      cond_bit = status[sel];
    end
    taken = (cond_bit == want_one);
  end

endmodule : bbf_branch_cond

// *** verilog/bbf_shifter.sv ***
`timescale 1ns/1ns
module bbf_shifter (
  // operand
  input wire bbf_pkg::bbf_shift_type kind,
  input wire logic [7:0] din,
  input wire logic cin,
  // result and flags
  output logic [7:0] dout,
  output logic c,
  output logic z,
  output logic n,
  output logic v,
  output logic s
);

  always_comb begin
    dout = din;
    c = cin;
    case (kind)
      bbf_pkg::sh_left_logical: begin
        dout = {din[6:0], 1'b0};
        c = din[7];
      end
      bbf_pkg::sh_right_logical: begin
        dout = {1'b0, din[7:1]};
        c = din[0];
      end
      bbf_pkg::sh_rotate_left: begin
        dout = {din[6:0], cin};
        c = din[7];
      end
      bbf_pkg::sh_rotate_right: begin
        dout = {cin, din[7:1]};
        c = din[0];
      end
      bbf_pkg::sh_right_arith: begin
        dout = {din[7], din[7:1]};
        c = din[0];
      end
      default: begin
        dout = din;
        c = cin;
      end
    endcase
    z = (dout == 8'h00);
    n = dout[7];
    // overflow of a one-place shift is sign xor carry
    v = n ^ c;
    s = n ^ v;
  end

endmodule : bbf_shifter

// *** verif/bbf_exec_checker.sv ***
`timescale 1ns/1ns
module bbf_exec_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // instruction
  input wire logic instr_valid,
  input wire bbf_pkg::bbf_instr_type instr,
  input wire logic ready_q,
  // register and io side
  input wire logic [7:0] reg_rd_data,
  input wire bbf_pkg::bbf_reg_wb_type reg_wb_q,
  input wire logic [bbf_pkg::IO_ADDR_W-1:0] io_addr_q,
  input wire logic [7:0] io_rd_data,
  input wire logic io_wr_en_q,
  input wire logic [7:0] io_wr_data_q,
  // core state
  input wire logic [bbf_pkg::PC_W-1:0] pc_q,
  input wire logic [7:0] status_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic [15:0] tgt;
  assign acc = clk_en && instr_valid && ready_q;
  assign tgt = pc_q + 16'h0001 + {{9{instr.offset[6]}}, instr.offset};
  // one refused cycle stands in for the pipeline flush
  sequence s_flush;
    !ready_q ##1 ready_q;
  endsequence
  sequence s_io_write;
    io_wr_en_q && io_wr_data_q ==
      ($past(io_rd_data) | (8'h01 << $past(instr.sel, 2)));
  endsequence
  property p_taken;
    acc && instr.op == bbf_pkg::op_branch_status_bit_set
      && status_q[instr.sel] |=> pc_q == $past(tgt) ##0 s_flush;
  endproperty
  a_taken: assert property (p_taken)
    else $error("taken branch target or timing wrong");
  property p_skip;
    acc && instr.op == bbf_pkg::op_branch_status_bit_clear
      && status_q[instr.sel] |=> pc_q == $past(pc_q) + 16'h0001 && ready_q;
  endproperty
  a_skip: assert property (p_skip)
    else $error("untaken branch wrong");
  property p_lt;
    acc && instr.op == bbf_pkg::op_branch_signed_lt
      && (status_q[2] ^ status_q[3]) |=> pc_q == $past(tgt);
  endproperty
  a_lt: assert property (p_lt)
    else $error("signed less branch not taken");
  property p_keep;
    acc && instr.op inside {[bbf_pkg::op_branch_status_bit_set:
      bbf_pkg::op_branch_irq_disabled]} |=> status_q == $past(status_q);
  endproperty
  a_keep: assert property (p_keep)
    else $error("branch altered flags");
  property p_io;
    acc && instr.op == bbf_pkg::op_io_bit_force_one |=>
      io_addr_q == $past(instr.io_addr) && !ready_q ##1 s_io_write;
  endproperty
  a_io: assert property (p_io)
    else $error("io bit force wrong");
  property p_lsl;
    acc && instr.op == bbf_pkg::op_shift_left_logical |=> reg_wb_q.en
      && reg_wb_q.data == {$past(reg_rd_data[6:0]), 1'b0}
      && status_q[0] == $past(reg_rd_data[7]);
  endproperty
  a_lsl: assert property (p_lsl)
    else $error("left shift wrong");
  property p_asr;
    acc && instr.op == bbf_pkg::op_shift_right_arith |=>
      reg_wb_q.data == {$past(reg_rd_data[7]), $past(reg_rd_data[7:1])}
      && status_q[0] == $past(reg_rd_data[0]);
  endproperty
  a_asr: assert property (p_asr)
    else $error("arithmetic shift wrong");
  property p_ror;
    acc && instr.op == bbf_pkg::op_rotate_right_carry |=>
      reg_wb_q.data == {$past(status_q[0]), $past(reg_rd_data[7:1])};
  endproperty
  a_ror: assert property (p_ror)
    else $error("rotate right wrong");
  property p_bst;
    acc && instr.op == bbf_pkg::op_bit_to_transfer_flag |=> status_q ==
      {$past(status_q[7]), $past(reg_rd_data[instr.sel]),
      $past(status_q[5:0])};
  endproperty
  a_bst: assert property (p_bst)
    else $error("bit store wrong");
  property p_flag;
    acc && instr.op == bbf_pkg::op_flag_force_one |=>
      status_q == ($past(status_q) | (8'h01 << $past(instr.sel)));
  endproperty
  a_flag: assert property (p_flag)
    else $error("indexed flag force wrong");
endmodule : bbf_exec_checker

bind bbf_exec bbf_exec_checker u_bbf_exec_checker (.ref_clk(ref_clk),
  .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
  .ready_q(ready_q), .reg_rd_data(reg_rd_data), .reg_wb_q(reg_wb_q),
  .io_addr_q(io_addr_q), .io_rd_data(io_rd_data), .io_wr_en_q(io_wr_en_q),
  .io_wr_data_q(io_wr_data_q), .pc_q(pc_q), .status_q(status_q));

// *** verif/bbf_exec_bench.sv ***
`timescale 1ns/1ns
module bbf_exec_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  bbf_pkg::bbf_instr_type instr = '0;
  logic ready_q;
  logic [7:0] reg_rd_data = 8'h00;
  bbf_pkg::bbf_reg_wb_type reg_wb_q;
  logic [4:0] io_addr_q;
  logic [4:0] io_a = 5'h1F;
  logic [7:0] io_rd_data = 8'h00;
  logic io_wr_en_q;
  logic [7:0] io_wr_data_q;
  logic [15:0] pc_q;
  logic [7:0] status_q;
  logic [15:0] exp_pc = 16'h0000;
  logic [7:0] exp_sr = 8'h00;
  int failures = 0;
  int compares = 0;

  always #2 ref_clk = ~ref_clk;

  bbf_exec u_bbf_exec (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .ready_q(ready_q),
    .reg_rd_data(reg_rd_data), .reg_wb_q(reg_wb_q), .io_addr_q(io_addr_q),
    .io_rd_data(io_rd_data), .io_wr_en_q(io_wr_en_q),
    .io_wr_data_q(io_wr_data_q), .pc_q(pc_q), .status_q(status_q));

  task automatic wrap_up;
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t pc %h expected %h", $time, got, exp);
    end
  endtask : chk16

  // valid stays up afterwards so back-to-back issues never glitch it
  task automatic issue(input bbf_pkg::bbf_op_type op, input logic [2:0] sel,
      input logic [6:0] ofs, input logic [7:0] rd);
    int n;
    n = 0;
    instr_valid = 1'b1;
    instr = {op, sel, ofs, 5'h0B, io_a};
    reg_rd_data = rd;
    while (ready_q !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // a core that never becomes ready counts as a mismatch here
    chk8({7'h00, ready_q}, 8'h01);
    @(posedge ref_clk);
    #1;
    exp_pc = exp_pc + 16'h0001;
  endtask : issue

  task automatic quiet;
    instr_valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : quiet

  task automatic setf(input logic [2:0] b, input logic v);
    issue(v ? bbf_pkg::op_flag_force_one : bbf_pkg::op_flag_force_zero, b,
      7'h00, 8'h00);
    exp_sr[b] = v;
    chk8(status_q, exp_sr);
  endtask : setf

  task automatic branch(input bbf_pkg::bbf_op_type op, input logic [2:0] sel,
      input logic tk);
    logic [6:0] ofs;
    ofs = exp_pc[0] ? 7'h40 : 7'h3F;
    issue(op, sel, ofs, 8'h00);
    if (tk) exp_pc = exp_pc + {{9{ofs[6]}}, ofs};
    chk16(pc_q, exp_pc);
    chk8(status_q, exp_sr);
  endtask : branch

  task automatic t_generic;
    for (int b = 0; b < 16; b++) begin
      setf(b[2:0], b < 8 || b[0]);
    end
  endtask : t_generic

  task automatic t_forces;
    logic [2:0] fb [7] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h4, 3'h6, 3'h7};
    for (int k = 0; k < 14; k++) begin
      issue(bbf_pkg::bbf_op_type'(int'(bbf_pkg::op_carry_on) + k), 3'h5,
        7'h00, 8'h00);
      exp_sr[fb[k / 2]] = !k[0];
      chk8(status_q, exp_sr);
    end
  endtask : t_forces

  task automatic t_branches;
    logic [2:0] fb [20] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0,
      3'h2, 3'h2, 3'h2, 3'h2, 3'h5, 3'h5, 3'h6, 3'h6, 3'h3, 3'h3, 3'h7, 3'h7};
    logic [19:0] want = 20'h55995;
    logic c;
    for (int k = 0; k < 20; k++) begin
      for (int v = 0; v < 4; v++) begin
        setf(fb[k], v[0]);
        if (k == 10 || k == 11) setf(3'h3, v[1]);
        c = (k == 10 || k == 11) ? exp_sr[2] ^ exp_sr[3] : exp_sr[fb[k]];
        branch(bbf_pkg::bbf_op_type'(int'(bbf_pkg::op_branch_status_bit_set)
          + k), fb[k], c == want[k]);
      end
    end
  endtask : t_branches

  task automatic t_shifts;
    logic [7:0] d;
    logic [7:0] r;
    logic co;
    for (int k = 0; k < 5; k++) begin
      for (int j = 0; j < 6; j++) begin
        d = j < 2 ? 8'h80 : (j < 4 ? 8'h01 : 8'hA5);
        setf(3'h0, j[0]);
        case (k)
          0: {co, r} = {d, 1'b0};
          1: {r, co} = {1'b0, d};
          2: {co, r} = {d, j[0]};
          3: {r, co} = {j[0], d};
          default: {r, co} = {d[7], d};
        endcase
        issue(bbf_pkg::bbf_op_type'(int'(bbf_pkg::op_shift_left_logical) + k),
          3'h0, 7'h00, d);
        exp_sr[4:0] = {co, r[7] ^ co, r[7], r == 8'h00, co};
        chk8(reg_wb_q.data, r);
        chk8(status_q, exp_sr);
        chk8({2'h0, reg_wb_q.en, reg_wb_q.addr}, 8'h2B);
      end
    end
    quiet();
    chk8({7'h00, reg_wb_q.en}, 8'h00);
  endtask : t_shifts

  task automatic t_bits;
    logic [7:0] p;
    logic [7:0] e;
    p = 8'h5A;
    for (int b = 0; b < 8; b++) begin
      issue(bbf_pkg::op_bit_to_transfer_flag, b[2:0], 7'h00, p);
      exp_sr[6] = p[b];
      chk8(status_q, exp_sr);
      issue(bbf_pkg::op_transfer_flag_to_bit, b[2:0], 7'h00, ~p);
      e = ~p;
      e[b] = exp_sr[6];
      chk8(reg_wb_q.data, e);
      chk8(status_q, exp_sr);
    end
  endtask : t_bits

  task automatic t_io;
    for (int k = 0; k < 2; k++) begin
      io_a = k ? 5'h00 : 5'h1F;
      issue(k ? bbf_pkg::op_io_bit_force_zero : bbf_pkg::op_io_bit_force_one,
        k ? 3'h7 : 3'h0, 7'h00, 8'h00);
      chk8({3'h0, io_addr_q}, {3'h0, io_a});
      io_rd_data = k ? 8'hFF : 8'h80;
      quiet();
      chk8({7'h00, io_wr_en_q}, 8'h01);
      chk8(io_wr_data_q, k ? 8'h7F : 8'h81);
      chk16(pc_q, exp_pc);
      chk8(status_q, exp_sr);
      quiet();
      chk8({7'h00, io_wr_en_q}, 8'h00);
    end
  endtask : t_io

  // an offered instruction must leave no trace while the enable is low
  task automatic t_freeze;
    clk_en = 1'b0;
    instr_valid = 1'b1;
    instr = {bbf_pkg::op_flag_force_one, 3'h1, 7'h00, 5'h0B, io_a};
    reg_rd_data = 8'h00;
    repeat (3) @(posedge ref_clk);
    #1;
    chk16(pc_q, exp_pc);
    chk8(status_q, exp_sr);
    clk_en = 1'b1;
    setf(3'h1, ~exp_sr[1]);
  endtask : t_freeze

  initial begin
    #40000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    chk16(pc_q, 16'h0000);
    chk8(status_q, 8'h00);
    t_generic();
    t_forces();
    t_branches();
    t_shifts();
    t_bits();
    t_io();
    t_freeze();
    wrap_up();
  end
endmodule : bbf_exec_bench
